// File: cgss_clk_gate.sv
`timescale 1ns/1ps
module cgss_clk_gate (
   // Free running clock.
   input wire logic clk_in,
   // Stop request, from a flop on clk_in.
   input wire logic stop_in,
   // Gated clock.
   output logic gclk_out
);

   logic enable;

   // The enable is latched while the clock is low so the gated clock never glitches.
   always_latch begin
      if (!clk_in) begin
         enable <= ~stop_in;
      end
   end

   assign gclk_out = clk_in & enable;

endmodule : cgss_clk_gate

// File: cgss_pkg.sv
package cgss_pkg;

   // Register indices on the serial register port.
   localparam logic [0:0] CGSS_REG_CLOCK_GATE = 1'h0;
   localparam logic [0:0] CGSS_REG_STATUS = 1'h1;

   // Clock gating control field positions.
   localparam int CGSS_BIT_DIGITAL = 11;
   localparam int CGSS_BIT_ACT_B = 5;
   localparam int CGSS_BIT_ACT_A = 4;
   localparam int CGSS_BIT_LOS_XTAL = 3;
   localparam int CGSS_BIT_LOS_B = 2;
   localparam int CGSS_BIT_LOS_A = 1;
   localparam int CGSS_BIT_FUSE = 0;

   // Writable bits of the gating register; bits 8 and 6 store but steer nothing.
   localparam logic [15:0] CGSS_GATE_RW_MASK = 16'h097f;
   localparam logic [15:0] CGSS_GATE_RESET = 16'h0000;
   localparam logic [7:0] CGSS_STATUS_RESET = 8'h00;

   // Startup status field positions.
   localparam int CGSS_STS_BIAS_TO = 5;
   localparam int CGSS_STS_LOAD_TO = 6;
   localparam int CGSS_STS_APLL_TO = 7;

   // Gated clock outputs, one per unit.
   localparam int CGSS_UNITS = 8;
   localparam int CGSS_CLK_FUSE = 0;
   localparam int CGSS_CLK_LOS_A = 1;
   localparam int CGSS_CLK_LOS_B = 2;
   localparam int CGSS_CLK_LOS_XTAL = 3;
   localparam int CGSS_CLK_ACT_A = 4;
   localparam int CGSS_CLK_ACT_B = 5;
   localparam int CGSS_CLK_DIGITAL = 6;
   localparam int CGSS_CLK_REG_BUS = 7;

   // Timing: figures in microseconds, counts in cycles of the 50 MHz clock.
   localparam int CGSS_MCLK_MHZ = 50;
   localparam int CGSS_BIAS_TIMEOUT_US = 2000;
   localparam int CGSS_LOAD_TIMEOUT_US = 10000;
   localparam int CGSS_APLL_TIMEOUT_US = 2000;
   localparam int CGSS_CLKCHK_US = 20;
   localparam int CGSS_BIAS_TIMEOUT_CYC = CGSS_BIAS_TIMEOUT_US * CGSS_MCLK_MHZ;
   localparam int CGSS_LOAD_TIMEOUT_CYC = CGSS_LOAD_TIMEOUT_US * CGSS_MCLK_MHZ;
   localparam int CGSS_APLL_TIMEOUT_CYC = CGSS_APLL_TIMEOUT_US * CGSS_MCLK_MHZ;
   localparam int CGSS_CLKCHK_CYC = CGSS_CLKCHK_US * CGSS_MCLK_MHZ;
   localparam int CGSS_CNT_W = 20;
   localparam logic [CGSS_CNT_W-1:0] CGSS_CNT_ZERO = 20'h00000;
   localparam logic [CGSS_CNT_W-1:0] CGSS_CNT_ONE = 20'h00001;

   // Startup sequence states, Gray coded along the normal path.
   typedef enum logic [2:0] {
      CGSS_ST_CLKCHK = 3'h0,
      CGSS_ST_BIAS = 3'h1,
      CGSS_ST_LOAD_COMMON = 3'h3,
      CGSS_ST_LOAD_USER = 3'h2,
      CGSS_ST_APLL = 3'h6,
      CGSS_ST_DONE = 3'h7
   } cgss_state_t;

   // Device startup status register layout.
   typedef struct packed {
      logic apll_timeout;
      logic load_timeout;
      logic bias_timeout;
      logic osc_fallback;
      logic device_ready;
      logic reserved;
      logic [1:0] config_loaded;
   } cgss_status_t;

endpackage : cgss_pkg

// File: cgss_top.sv
`timescale 1ns/1ps
module cgss_top
   import cgss_pkg::*;
#(
   parameter int BIAS_TIMEOUT_CYC = CGSS_BIAS_TIMEOUT_CYC,
   parameter int LOAD_TIMEOUT_CYC = CGSS_LOAD_TIMEOUT_CYC,
   parameter int APLL_TIMEOUT_CYC = CGSS_APLL_TIMEOUT_CYC
) (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Serial register port, already in the mclk domain.
   input wire logic reg_sel_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   output logic reg_ack_out,
   // Startup partners.
   input wire logic sysdiv_clk_in,
   input wire logic bias_cal_done_in,
   input wire logic fuse_load_done_in,
   input wire logic apll_lock_in,
   input wire logic [3:0] config_sel_in,
   output logic bias_cal_start_out,
   output logic fuse_load_req_out,
   output logic fuse_load_common_out,
   output logic [1:0] fuse_load_idx_out,
   output logic ring_osc_sel_out,
   // Gated unit clocks.
   output logic [CGSS_UNITS-1:0] unit_clk_out
);

   // Refuse timeouts that the shared stage counter cannot reach.
   if (BIAS_TIMEOUT_CYC < 1 || BIAS_TIMEOUT_CYC >= (1 << CGSS_CNT_W) ||
       LOAD_TIMEOUT_CYC < 1 || LOAD_TIMEOUT_CYC >= (1 << CGSS_CNT_W) ||
       APLL_TIMEOUT_CYC < 1 || APLL_TIMEOUT_CYC >= (1 << CGSS_CNT_W)) begin : g_bad_timeout
      $error("cgss_top: timeout count out of range");
   end

   localparam logic [CGSS_CNT_W-1:0] BIAS_LAST = CGSS_CNT_W'(BIAS_TIMEOUT_CYC - 1);
   localparam logic [CGSS_CNT_W-1:0] LOAD_LAST = CGSS_CNT_W'(LOAD_TIMEOUT_CYC - 1);
   localparam logic [CGSS_CNT_W-1:0] APLL_LAST = CGSS_CNT_W'(APLL_TIMEOUT_CYC - 1);
   localparam logic [CGSS_CNT_W-1:0] CHK_LAST = CGSS_CNT_W'(CGSS_CLKCHK_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pins from outside the mclk domain.

   logic [1:0] div_sync;
   logic [1:0] lock_sync;
   logic div_seen;
   logic [2:0] div_arm;
   logic [1:0] next_div_sync;
   logic [1:0] next_lock_sync;
   logic next_div_seen;
   logic [2:0] next_div_arm;
   logic div_edge;

   // The third stage only serves the edge detector, keeping the first stage private.
   always_comb begin
      next_div_sync = {div_sync[0], sysdiv_clk_in};
      next_lock_sync = {lock_sync[0], apll_lock_in};
      next_div_seen = div_sync[1];
      next_div_arm = {div_arm[1:0], 1'h1};
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_sync <= 2'h0;
         lock_sync <= 2'h0;
         div_seen <= 1'h0;
         div_arm <= 3'h0;
      end else begin
         div_sync <= next_div_sync;
         lock_sync <= next_lock_sync;
         div_seen <= next_div_seen;
         div_arm <= next_div_arm;
      end
   end

   // Edges count only once the pipeline has refilled after reset; otherwise a
   // divider stuck high would look like a running one and hide the fallback.
   assign div_edge = div_arm[2] & (div_sync[1] ^ div_seen);

   ////////////////////////////////////////////////////////////////////////////////
   // Startup sequence.

   cgss_state_t state;
   cgss_state_t next_state;
   logic [CGSS_CNT_W-1:0] cnt;
   logic [CGSS_CNT_W-1:0] next_cnt;
   cgss_status_t status;
   cgss_status_t next_status;
   logic ring_sel;
   logic next_ring_sel;
   logic [1:0] cfg_idx;
   logic [1:0] next_cfg_idx;

   // One counter times each stage; both loads share the one load budget.
   always_comb begin
      next_state = state;
      next_cnt = cnt + CGSS_CNT_ONE;
      next_status = status;
      next_ring_sel = ring_sel;
      next_cfg_idx = cfg_idx;
      unique case (state)
         CGSS_ST_CLKCHK: begin
            next_cfg_idx = config_sel_in[1:0];
            if (div_edge) begin
               next_state = CGSS_ST_BIAS;
               next_cnt = CGSS_CNT_ZERO;
            end else if (cnt >= CHK_LAST) begin
               next_ring_sel = 1'h1;
               next_status.osc_fallback = 1'h1;
               next_state = CGSS_ST_BIAS;
               next_cnt = CGSS_CNT_ZERO;
            end
         end
         CGSS_ST_BIAS: begin
            if (bias_cal_done_in) begin
               next_state = CGSS_ST_LOAD_COMMON;
               next_cnt = CGSS_CNT_ZERO;
            end else if (cnt >= BIAS_LAST) begin
               next_status.bias_timeout = 1'h1;
               next_state = CGSS_ST_LOAD_COMMON;
               next_cnt = CGSS_CNT_ZERO;
            end
         end
         CGSS_ST_LOAD_COMMON: begin
            if (fuse_load_done_in) begin
               next_state = CGSS_ST_LOAD_USER;
            end else if (cnt >= LOAD_LAST) begin
               next_status.load_timeout = 1'h1;
               next_state = CGSS_ST_APLL;
               next_cnt = CGSS_CNT_ZERO;
            end
         end
         CGSS_ST_LOAD_USER: begin
            if (fuse_load_done_in) begin
               next_status.device_ready = 1'h1;
               next_status.config_loaded = cfg_idx;
               next_state = CGSS_ST_APLL;
               next_cnt = CGSS_CNT_ZERO;
            end else if (cnt >= LOAD_LAST) begin
               next_status.load_timeout = 1'h1;
               next_state = CGSS_ST_APLL;
               next_cnt = CGSS_CNT_ZERO;
            end
         end
         CGSS_ST_APLL: begin
            if (lock_sync[1]) begin
               next_state = CGSS_ST_DONE;
               next_cnt = CGSS_CNT_ZERO;
            end else if (cnt >= APLL_LAST) begin
               next_status.apll_timeout = 1'h1;
               next_state = CGSS_ST_DONE;
               next_cnt = CGSS_CNT_ZERO;
            end
         end
         CGSS_ST_DONE: begin
            next_cnt = cnt;
         end
         default: begin
            next_state = CGSS_ST_DONE;
            next_cnt = CGSS_CNT_ZERO;
         end
      endcase
      next_status.reserved = 1'h0;
   end

   // Status clears only on power-on reset; nothing in software can rewrite it.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= CGSS_ST_CLKCHK;
         cnt <= CGSS_CNT_ZERO;
         status <= CGSS_STATUS_RESET;
         ring_sel <= 1'h0;
         cfg_idx <= 2'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         status <= next_status;
         ring_sel <= next_ring_sel;
         cfg_idx <= next_cfg_idx;
      end
   end

   // Request levels are held for the whole stage; the partner answers with a done pulse.
   assign bias_cal_start_out = (state == CGSS_ST_BIAS);
   assign fuse_load_req_out = (state == CGSS_ST_LOAD_COMMON) || (state == CGSS_ST_LOAD_USER);
   assign fuse_load_common_out = (state == CGSS_ST_LOAD_COMMON);
   assign fuse_load_idx_out = cfg_idx;
   assign ring_osc_sel_out = ring_sel;

   ////////////////////////////////////////////////////////////////////////////////
   // Register port.

   logic [15:0] gate;
   logic [15:0] next_gate;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic ack;
   logic next_ack;
   logic bus_dead;

   // Once the catch-all gate is set the port clock is gone; only reset revives it.
   assign bus_dead = gate[CGSS_BIT_DIGITAL];

   always_comb begin
      next_gate = gate;
      next_rdata = rdata;
      next_ack = 1'h0;
      if (!bus_dead && reg_wr_in) begin
         next_ack = 1'h1;
         if (reg_sel_in == CGSS_REG_CLOCK_GATE) begin
            next_gate = reg_wdata_in & CGSS_GATE_RW_MASK;
         end
      end else if (!bus_dead && reg_rd_in) begin
         next_ack = 1'h1;
         if (reg_sel_in == CGSS_REG_CLOCK_GATE) begin
            next_rdata = gate;
         end else begin
            next_rdata = {8'h00, status};
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gate <= CGSS_GATE_RESET;
         rdata <= 16'h0000;
         ack <= 1'h0;
      end else begin
         gate <= next_gate;
         rdata <= next_rdata;
         ack <= next_ack;
      end
   end

   assign reg_rdata_out = rdata;
   assign reg_ack_out = ack;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock gates, one per unit.

   logic [CGSS_UNITS-1:0] stop;

   always_comb begin
      stop = '0;
      stop[CGSS_CLK_FUSE] = gate[CGSS_BIT_FUSE];
      stop[CGSS_CLK_LOS_A] = gate[CGSS_BIT_LOS_A];
      stop[CGSS_CLK_LOS_B] = gate[CGSS_BIT_LOS_B];
      stop[CGSS_CLK_LOS_XTAL] = gate[CGSS_BIT_LOS_XTAL];
      stop[CGSS_CLK_ACT_A] = gate[CGSS_BIT_ACT_A];
      stop[CGSS_CLK_ACT_B] = gate[CGSS_BIT_ACT_B];
      stop[CGSS_CLK_DIGITAL] = gate[CGSS_BIT_DIGITAL];
      stop[CGSS_CLK_REG_BUS] = gate[CGSS_BIT_DIGITAL];
   end

   for (genvar i = 0; i < CGSS_UNITS; i++) begin : g_gate
      cgss_clk_gate u_gate (
         .clk_in(mclk_in),
         .stop_in(stop[i]),
         .gclk_out(unit_clk_out[i])
      );
   end

endmodule : cgss_top

// File: cgss_top_chk.sv
`timescale 1ns/1ps
module cgss_top_chk
   import cgss_pkg::*;
(
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Register port.
   input wire logic reg_sel_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic reg_ack_out,
   // Startup outputs.
   input wire logic bias_cal_start_out,
   input wire logic fuse_load_req_out,
   input wire logic fuse_load_common_out,
   input wire logic ring_osc_sel_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   logic [15:0] gate_q;
   logic [15:0] next_gate_q;
   ////////////////////////////////////////////////////////////////
   // A shadow of the gating register lets us predict the lock-out.
   always_comb begin
      next_gate_q = gate_q;
      if (reg_wr_in && !reg_sel_in && !gate_q[11]) begin
         next_gate_q = reg_wdata_in & CGSS_GATE_RW_MASK;
      end
   end
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gate_q <= 16'h0000;
      end else begin
         gate_q <= next_gate_q;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Accepted accesses, and reads of each register.
   sequence s_take;
      (reg_wr_in || reg_rd_in) && !gate_q[11];
   endsequence
   sequence s_rd_gate;
      reg_rd_in && !reg_wr_in && !reg_sel_in && !gate_q[11];
   endsequence
   sequence s_rd_sts;
      reg_rd_in && !reg_wr_in && reg_sel_in && !gate_q[11];
   endsequence
   a_access_acked: assert property (s_take |=> reg_ack_out)
      else $error("access not acknowledged");
   a_locked_refused: assert property (gate_q[11] |=> !reg_ack_out)
      else $error("access acknowledged after lock");
   a_idle_no_ack: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
      else $error("ack without access");
   a_gate_readback: assert property (s_rd_gate |=> reg_rdata_out == gate_q)
      else $error("gating readback wrong");
   a_status_reserved: assert property (s_rd_sts |=> reg_rdata_out[15:8] == 8'h00 && !reg_rdata_out[2])
      else $error("status reserved bits set");
   a_fallback_sticky: assert property (ring_osc_sel_out |=> $stable(ring_osc_sel_out))
      else $error("fallback select dropped");
   a_common_in_load: assert property (fuse_load_common_out |-> fuse_load_req_out)
      else $error("common load without request");
   a_bias_apart: assert property (bias_cal_start_out |-> !fuse_load_req_out)
      else $error("bias and load overlap");
endmodule : cgss_top_chk
bind cgss_top cgss_top_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
   .bias_cal_start_out(bias_cal_start_out), .fuse_load_req_out(fuse_load_req_out),
   .fuse_load_common_out(fuse_load_common_out), .ring_osc_sel_out(ring_osc_sel_out));

// File: cgss_top_tb.sv
`timescale 1ns/1ps
module cgss_top_tb
   import cgss_pkg::*;
;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic reg_sel_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic sysdiv_clk_in = 1'b0;
   logic bias_cal_done_in = 1'b0;
   logic fuse_load_done_in = 1'b0;
   logic apll_lock_in = 1'b0;
   logic [3:0] config_sel_in = 4'h6;
   logic [15:0] reg_rdata_out;
   logic reg_ack_out;
   logic bias_cal_start_out;
   logic fuse_load_req_out;
   logic fuse_load_common_out;
   logic [1:0] fuse_load_idx_out;
   logic ring_osc_sel_out;
   logic [7:0] unit_clk_out;
   logic div_run = 1'b0;
   logic ok;
   logic [15:0] q;
   int bad_count = 0;
   int cmp_count = 0;
   int n;
   // Short timeouts keep the run brief; expectations use these values.
   cgss_top #(.BIAS_TIMEOUT_CYC(20), .LOAD_TIMEOUT_CYC(50), .APLL_TIMEOUT_CYC(20)) dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_sel_in(reg_sel_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
      .sysdiv_clk_in(sysdiv_clk_in), .bias_cal_done_in(bias_cal_done_in),
      .fuse_load_done_in(fuse_load_done_in), .apll_lock_in(apll_lock_in),
      .config_sel_in(config_sel_in), .bias_cal_start_out(bias_cal_start_out),
      .fuse_load_req_out(fuse_load_req_out), .fuse_load_common_out(fuse_load_common_out),
      .fuse_load_idx_out(fuse_load_idx_out), .ring_osc_sel_out(ring_osc_sel_out),
      .unit_clk_out(unit_clk_out));
   ////////////////////////////////////////////////////////////////
   // Clock, and a divider that only toggles when asked to.
   always #10 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      if (div_run) begin
         sysdiv_clk_in <= ~sysdiv_clk_in;
      end
   end
   ////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One strobe cycle, then ack and data are taken one cycle later.
   task acc(input logic w, input logic s, input logic [15:0] d);
      @(posedge mclk_in);
      reg_wr_in <= w;
      reg_rd_in <= !w;
      reg_sel_in <= s;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      #1;
      ok = reg_ack_out;
      q = reg_rdata_out;
   endtask : acc
   // Gated clocks are looked at mid high phase, where a stopped one is low.
   task clk_chk(input logic [7:0] stop);
      repeat (3) @(posedge mclk_in);
      #5;
      chk("unit clocks", {8'h00, ~stop}, {8'h00, unit_clk_out});
   endtask : clk_chk
   task rst_dut;
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge mclk_in);
      rst_n_in <= 1'b1;
   endtask : rst_dut
   task pulse(input logic b);
      @(posedge mclk_in);
      if (b) bias_cal_done_in <= 1'b1;
      else fuse_load_done_in <= 1'b1;
      @(posedge mclk_in);
      bias_cal_done_in <= 1'b0;
      fuse_load_done_in <= 1'b0;
   endtask : pulse
   ////////////////////////////////////////////////////////////////
   task t_reset;
      acc(1'b0, 1'b0, 16'h0000);
      chk("gate after reset", 16'h0000, q);
      acc(1'b0, 1'b1, 16'h0000);
      chk("status after reset", 16'h0000, q);
   endtask : t_reset
   task t_startup;
      div_run <= 1'b1;
      for (n = 0; n < 200 && bias_cal_start_out !== 1'b1; n++) begin @(posedge mclk_in); #1; end
      chk("bias start", 16'h0001, {15'h0, bias_cal_start_out});
      pulse(1'b1);
      for (n = 0; n < 50 && fuse_load_common_out !== 1'b1; n++) begin @(posedge mclk_in); #1; end
      chk("common load", 16'h0001, {15'h0, fuse_load_req_out});
      pulse(1'b0);
      #1;
      chk("user load", 16'h0001, {14'h0, fuse_load_common_out, fuse_load_req_out});
      chk("user index", 16'h0002, {14'h0, fuse_load_idx_out});
      pulse(1'b0);
      apll_lock_in <= 1'b1;
      repeat (8) @(posedge mclk_in);
      acc(1'b0, 1'b1, 16'h0000);
      chk("status loaded", 16'h000a, q);
      chk("no fallback", 16'h0000, {15'h0, ring_osc_sel_out});
      acc(1'b1, 1'b1, 16'h00ff);
      acc(1'b0, 1'b1, 16'h0000);
      chk("status after write", 16'h000a, q);
      acc(1'b0, 1'b0, 16'h0000);
      chk("gate after load", 16'h0000, q);
   endtask : t_startup
   task t_gates;
      for (int i = 0; i < 6; i++) begin
         acc(1'b1, 1'b0, 16'h0001 << i);
         acc(1'b0, 1'b0, 16'h0000);
         chk("gate readback", 16'h0001 << i, q);
         clk_chk(8'h01 << i);
      end
      acc(1'b1, 1'b0, 16'hf7ff);
      acc(1'b0, 1'b0, 16'h0000);
      chk("gate mask", 16'h017f, q);
      clk_chk(8'h3f);
      acc(1'b1, 1'b0, 16'h0000);
      clk_chk(8'h00);
   endtask : t_gates
   // Dead divider and silent partners: each stage entered times out; the user load is never reached.
   task t_timeouts;
      @(posedge mclk_in);
      div_run <= 1'b0;
      apll_lock_in <= 1'b0;
      config_sel_in <= 4'h4;
      rst_dut();
      repeat (1400) @(posedge mclk_in);
      #1;
      chk("fallback select", 16'h0001, {15'h0, ring_osc_sel_out});
      acc(1'b0, 1'b1, 16'h0000);
      chk("status timeouts", 16'h00f0, q);
   endtask : t_timeouts
   // The catch-all gate stops the register clock, so this goes last.
   task t_lock;
      acc(1'b1, 1'b0, 16'h0800);
      chk("lock ack", 16'h0001, {15'h0, ok});
      clk_chk(8'hc0);
      acc(1'b0, 1'b0, 16'h0000);
      chk("locked read", 16'h0000, {15'h0, ok});
   endtask : t_lock
   ////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // The sequence needs about 1500 cycles; the watchdog allows 20000.
   initial begin
      #400000;
      bad_count++;
      wrap_up();
   end
   initial begin
      rst_dut();
      t_reset();
      t_startup();
      t_gates();
      t_timeouts();
      t_lock();
      wrap_up();
   end
endmodule : cgss_top_tb
